// *** logic/eqc_bank.sv ***
// Equalizer control and status register bank with APB slave, lane fan-out and interrupt
//
// Notes on behaviour
// - mode 1 plus override: lane strength used
// - zero override selects programmed zero code
// - freeze holds adaptation when fully adaptive
// - mode: off-flat, on, precursor, postcursor
// - zero code global, only under override
// - automatic zero: 1f, 1f, 1b, 08
// - zero codes map to fixed frequencies
// - sixteen lane setup registers from 1d0
// - gain lift 0, 2, 4, 6 dB
// - sixteen read-only lane reports from 1e0
// - reported level is thermometer bit count
// - reports carry above and below flags
`timescale 1ns/100ps
`default_nettype none
`include "eqc_regs.svh"
module eqc_bank #(
  parameter int LANES = 16,
  parameter int THERM_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eqc_pkg::eqc_rate_t lane_rate,
  input wire logic [LANES*THERM_W-1:0] lane_therm,
  input wire logic [LANES-1:0] analysis_above_flag,
  input wire logic [LANES-1:0] analysis_below_flag,
  output eqc_pkg::eqc_mode_t eq_operating_mode,
  output logic eq_flat_max_gain,
  output logic level_override,
  output logic adapt_freeze,
  output eqc_pkg::eqc_zero_t zero_code,
  output logic [LANES*5-1:0] lane_strength,
  output logic [LANES*2-1:0] lane_gain_lift,
  output logic irq
);
  import eqc_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] ctrl_reg; // Global control
  logic [7:0] ctrl_next;
  logic [7:0] zsel_reg; // Zero select
  logic [7:0] zsel_next;
  logic [7:0] setup_reg [LANES]; // Lane setup
  logic [2:0] int_stat_reg; // Sticky events
  logic [2:0] int_stat_next;
  logic [2:0] int_en_reg; // Interrupt enable
  logic [2:0] int_en_next;
  logic [31:0] rdata_reg; // Read data
  logic [31:0] rdata_next;
  logic [1:0] rate_s1_reg; // Speed setting sync stage 1
  logic [1:0] rate_s2_reg; // Speed setting sync stage 2
  logic mode_flat_reg; // Flat maximum gain drive
  logic lovr_reg; // Level override drive
  logic freeze_reg; // Freeze drive
  eqc_mode_t mode_reg; // Mode drive

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire [8:0] idx = paddr[10:2]; // Register index
  wire aligned = (paddr[1:0] == 2'b00) && !paddr[11];
  wire hit_ctrl = aligned && (idx == `EQC_IDX_GLOBAL_CTRL);
  wire hit_zsel = aligned && (idx == `EQC_IDX_ZERO_SEL);
  wire hit_ist = aligned && (idx == `EQC_IDX_INT_STATUS);
  wire hit_iclr = aligned && (idx == `EQC_IDX_INT_CLEAR);
  wire hit_ien = aligned && (idx == `EQC_IDX_INT_ENABLE);
  wire hit_setup = aligned && ({idx[8:4], 4'h0} == `EQC_IDX_LANE_SETUP);
  wire hit_rep = aligned && ({idx[8:4], 4'h0} == `EQC_IDX_LANE_REPORT);
  wire [3:0] lane_sel = idx[3:0]; // Lane addressed
  wire hit_any = hit_ctrl | hit_zsel | hit_ist | hit_iclr | hit_ien | hit_setup | hit_rep;
  wire access = psel && penable; // Access phase
  wire wr_en = access && pwrite && hit_any; // Write taken this edge

  // Zero wait states; unmapped or misaligned gets an error
  assign pready = access;
  assign pslverr = access && !hit_any;
  assign prdata = rdata_reg;

  // ----------------------------------------
  // Lane status
  // ----------------------------------------
  logic [4:0] lvl [LANES]; // Level in effect per lane
  logic [LANES-1:0] above; // Above flags
  logic [LANES-1:0] below; // Below flags
  logic [LANES-1:0] lvl_chg; // Level change pulses
  logic [LANES-1:0] above_d_reg; // Previous above flags
  logic [LANES-1:0] below_d_reg; // Previous below flags

  // freeze only in fully adaptive mode
  wire freeze_now = (ctrl_reg[1:0] == EQC_MODE_ON) && !ctrl_reg[`EQC_CTRL_LOVR_BIT]
                    && ctrl_reg[`EQC_CTRL_FREEZE_BIT];

  // One status block per lane
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      eqc_lane_status #(.THERM_W(THERM_W)) u_stat (
        .clk(clk),
        .rstn(rstn),
        .therm_in(lane_therm[g*THERM_W +: THERM_W]),
        .above_in(analysis_above_flag[g]),
        .below_in(analysis_below_flag[g]),
        .freeze(freeze_now),
        .level(lvl[g]),
        .above(above[g]),
        .below(below[g]),
        .level_chg(lvl_chg[g])
      );
      // Lane strength and gain lift drives from the setup register
      assign lane_strength[g*5 +: 5] = setup_reg[g][`EQC_LANE_STR_LSB +: 5];
      assign lane_gain_lift[g*2 +: 2] = setup_reg[g][`EQC_LANE_LIFT_LSB +: 2];
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // report byte assembly
  wire [7:0] rep_byte = {1'b0, above[lane_sel], below[lane_sel], lvl[lane_sel]};
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_next[7:0] = ctrl_reg;
    end else if (hit_zsel) begin
      rdata_next[7:0] = zsel_reg;
    end else if (hit_ist) begin
      rdata_next[2:0] = int_stat_reg;
    end else if (hit_ien) begin
      rdata_next[2:0] = int_en_reg;
    end else if (hit_setup) begin
      rdata_next[7:0] = setup_reg[lane_sel];
    end else if (hit_rep) begin
      rdata_next[7:0] = rep_byte;
    end
  end

  // Read data captured in the setup phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Global registers
  // ----------------------------------------
  assign ctrl_next = (wr_en && hit_ctrl) ? pwdata[7:0] : ctrl_reg;
  assign zsel_next = (wr_en && hit_zsel) ? pwdata[7:0] : zsel_reg;
  assign int_en_next = (wr_en && hit_ien) ? pwdata[2:0] : int_en_reg;

  // Global control, zero select and enable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `EQC_RST_GLOBAL_CTRL;
      zsel_reg <= `EQC_RST_ZERO_SEL;
      int_en_reg <= `EQC_RST_INT;
    end else begin
      ctrl_reg <= ctrl_next;
      zsel_reg <= zsel_next;
      int_en_reg <= int_en_next;
    end
  end

  generate
    for (g = 0; g < LANES; g++) begin : g_setup
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          setup_reg[g] <= `EQC_RST_LANE_SETUP;
        end else if (wr_en && hit_setup && lane_sel == g) begin
          setup_reg[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Equalizer drives
  // ----------------------------------------
  // mode decode
  wire mode_flat = (ctrl_reg[1:0] == EQC_MODE_OFF);
  // level override only in mode 1
  wire lovr_now = (ctrl_reg[1:0] == EQC_MODE_ON) && ctrl_reg[`EQC_CTRL_LOVR_BIT];

  // Registered mode, override and freeze drives
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= EQC_MODE_OFF;
      mode_flat_reg <= 1'b1;
      lovr_reg <= 1'b0;
      freeze_reg <= 1'b0;
    end else begin
      mode_reg <= eqc_mode_t'(ctrl_reg[1:0]);
      mode_flat_reg <= mode_flat;
      lovr_reg <= lovr_now;
      freeze_reg <= freeze_now;
    end
  end
  assign eq_operating_mode = mode_reg;
  assign eq_flat_max_gain = mode_flat_reg;
  assign level_override = lovr_reg;
  assign adapt_freeze = freeze_reg;

  // Speed setting synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rate_s1_reg <= 2'h0;
      rate_s2_reg <= 2'h0;
    end else begin
      rate_s1_reg <= lane_rate;
      rate_s2_reg <= rate_s1_reg;
    end
  end

  // code sent as-is, frequency fixed by code
  eqc_zero_sel u_zero (
    .clk(clk),
    .rstn(rstn),
    .rate(rate_s2_reg),
    .zero_override(ctrl_reg[`EQC_CTRL_ZOVR_BIT]),
    .zero_select(zsel_reg[4:0]),
    .zero_code(zero_code)
  );

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire ev_above = |(above & ~above_d_reg); // Any lane rose above
  wire ev_below = |(below & ~below_d_reg); // Any lane rose below
  wire ev_level = |lvl_chg; // Any level moved
  wire [2:0] ev = {ev_level, ev_below, ev_above};
  wire [2:0] clr = (wr_en && hit_iclr) ? pwdata[2:0] : 3'h0;
  // Set wins over a clear in the same cycle
  assign int_stat_next = (int_stat_reg & ~clr) | ev;

  // Sticky status and edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_stat_reg <= `EQC_RST_INT;
      above_d_reg <= '0;
      below_d_reg <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
      above_d_reg <= above;
      below_d_reg <= below;
    end
  end
  assign irq = |(int_stat_reg & int_en_reg);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // override low outside mode 1
  chk_override_drive: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_reg[1:0] != 2'b01 |=> !level_override)
    else $error("level override active outside mode 1");
  // flat response only in mode 0
  chk_mode_flat_gain: assert property (@(posedge clk) disable iff (!rstn)
    ##1 eq_flat_max_gain == ($past(ctrl_reg[1:0]) == 2'b00))
    else $error("flat gain drive disagrees with mode");
  chk_freeze_gate: assert property (@(posedge clk) disable iff (!rstn)
    adapt_freeze |-> $past(ctrl_reg[1:0]) == 2'b01 && !$past(ctrl_reg[4]) && $past(ctrl_reg[2]))
    else $error("freeze driven outside fully adaptive mode");
  // lane setup write lands in lane strength
  chk_setup_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_en && hit_setup && lane_sel == 4'h0 |=> lane_strength[4:0] == $past(pwdata[4:0]))
    else $error("lane 0 setup write not applied");
  chk_report_read: assert property (@(posedge clk) disable iff (!rstn)
    psel && !penable && hit_rep |=> prdata[7] == 1'b0 && prdata[31:8] == 24'h0)
    else $error("report read has stray bits");
  // Interrupt stays set until cleared
  chk_int_sticky_set: assert property (@(posedge clk) disable iff (!rstn)
    int_stat_reg[0] && !(wr_en && hit_iclr && pwdata[0]) |=> int_stat_reg[0])
    else $error("sticky status bit dropped without clear");
  // Interrupt output tracks enabled status
  chk_irq_level_out: assert property (@(posedge clk) disable iff (!rstn)
    int_en_reg[0] && int_stat_reg[0] |-> irq)
    else $error("enabled status set but interrupt low");

  cov_override_mode: cover property (@(posedge clk) disable iff (!rstn) level_override);
  cov_freeze_mode: cover property (@(posedge clk) disable iff (!rstn) adapt_freeze);
  cov_report_read: cover property (@(posedge clk) disable iff (!rstn) access && hit_rep);
  cov_irq_raise: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
endmodule : eqc_bank
`default_nettype wire

// *** logic/eqc_regs.svh ***
// Register indices, field positions, reset values and automatic zero codes of the equalizer control bank
`ifndef EQC_REGS_SVH
`define EQC_REGS_SVH

// Register indices; byte address is four times the index
`define EQC_IDX_GLOBAL_CTRL 9'h1c2
`define EQC_IDX_ZERO_SEL 9'h1c3
`define EQC_IDX_INT_STATUS 9'h1c8
`define EQC_IDX_INT_CLEAR 9'h1c9
`define EQC_IDX_INT_ENABLE 9'h1ca
`define EQC_IDX_LANE_SETUP 9'h1d0
`define EQC_IDX_LANE_REPORT 9'h1e0

// Global control fields
`define EQC_CTRL_MODE_LSB 0
`define EQC_CTRL_FREEZE_BIT 2
`define EQC_CTRL_ZOVR_BIT 3
`define EQC_CTRL_LOVR_BIT 4

// Lane setup fields
`define EQC_LANE_STR_LSB 0
`define EQC_LANE_LIFT_LSB 5

// Lane report fields
`define EQC_REP_BELOW_BIT 5
`define EQC_REP_ABOVE_BIT 6

// Interrupt status bits
`define EQC_INT_ABOVE_BIT 0
`define EQC_INT_BELOW_BIT 1
`define EQC_INT_LEVEL_BIT 2

// Reset values
`define EQC_RST_GLOBAL_CTRL 8'h00
`define EQC_RST_ZERO_SEL 8'h00
`define EQC_RST_LANE_SETUP 8'h08
`define EQC_RST_INT 3'h0

// Automatic zero codes per lane speed setting
`define EQC_ZERO_RATE01 5'h1f
`define EQC_ZERO_RATE2 5'h1b
`define EQC_ZERO_RATE3 5'h08

`endif

// *** logic/eqc_pkg.sv ***
// Types shared by the equalizer control bank
package eqc_pkg;
  // Global operating mode
  typedef enum logic [1:0] {
    EQC_MODE_OFF = 2'b00,
    EQC_MODE_ON = 2'b01,
    EQC_MODE_PRE = 2'b10,
    EQC_MODE_POST = 2'b11
  } eqc_mode_t;
  // Lane speed setting
  typedef logic [1:0] eqc_rate_t;
  // Zero frequency code
  typedef logic [4:0] eqc_zero_t;
endpackage : eqc_pkg

// *** logic/eqc_zero_sel.sv ***
// Zero frequency code selection, programmed or automatic per lane speed
`timescale 1ns/100ps
`default_nettype none
`include "eqc_regs.svh"
module eqc_zero_sel (
  input wire logic clk,
  input wire logic rstn,
  input wire eqc_pkg::eqc_rate_t rate,
  input wire logic zero_override,
  input wire eqc_pkg::eqc_zero_t zero_select,
  output eqc_pkg::eqc_zero_t zero_code
);
  import eqc_pkg::*;

  // ----------------------------------------
  // Automatic code table
  // ----------------------------------------
  eqc_zero_t auto_code; // Code that follows the speed setting
  eqc_zero_t code_next; // Code chosen this cycle
  eqc_zero_t code_reg; // Code driven to the equalizer

  assign auto_code = (rate == 2'h3) ? `EQC_ZERO_RATE3 :
                     (rate == 2'h2) ? `EQC_ZERO_RATE2 : `EQC_ZERO_RATE01;
  assign code_next = zero_override ? zero_select : auto_code;

  // Output register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      code_reg <= `EQC_ZERO_RATE01;
    end else begin
      code_reg <= code_next;
    end
  end
  assign zero_code = code_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // automatic code check
  chk_zero_auto_code: assert property (@(posedge clk) disable iff (!rstn)
    !zero_override && rate == 2'h2 |=> zero_code == 5'h1b)
    else $error("automatic zero code wrong for rate 2");
  chk_zero_override_code: assert property (@(posedge clk) disable iff (!rstn)
    zero_override |=> zero_code == $past(zero_select))
    else $error("programmed zero code not applied");
endmodule : eqc_zero_sel
`default_nettype wire

// *** logic/eqc_lane_status.sv ***
// One lane's level report: synchronised thermometer count, freeze hold and analysis flags
`timescale 1ns/100ps
`default_nettype none
module eqc_lane_status #(
  parameter int THERM_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [THERM_W-1:0] therm_in,
  input wire logic above_in,
  input wire logic below_in,
  input wire logic freeze,
  output logic [4:0] level,
  output logic above,
  output logic below,
  output logic level_chg
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [THERM_W+1:0] sync1_reg; // First stage, read only by second stage
  logic [THERM_W+1:0] sync2_reg; // Second stage
  logic [4:0] count; // Bits set in synced thermometer
  logic [4:0] level_reg; // Level shown to software
  logic above_reg; // Above flag
  logic below_reg; // Below flag
  logic chg_reg; // Level moved this cycle

  // Two-flop synchroniser for all analog status lines
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {above_in, below_in, therm_in};
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    count = 5'h00;
    for (int i = 0; i < THERM_W; i++) begin
      count = count + {4'h0, sync2_reg[i]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level_reg <= 5'h00;
      chg_reg <= 1'b0;
    end else begin
      level_reg <= freeze ? level_reg : count;
      chg_reg <= !freeze && (count != level_reg);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      above_reg <= 1'b0;
      below_reg <= 1'b0;
    end else begin
      above_reg <= sync2_reg[THERM_W+1];
      below_reg <= sync2_reg[THERM_W];
    end
  end

  assign level = level_reg;
  assign above = above_reg;
  assign below = below_reg;
  assign level_chg = chg_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // frozen level stays put
  chk_freeze_level_hold: assert property (@(posedge clk) disable iff (!rstn)
    freeze [*2] |-> $stable(level))
    else $error("level moved while adaptation frozen");
  chk_level_count_match: assert property (@(posedge clk) disable iff (!rstn)
    !freeze |=> level == $past(count))
    else $error("reported level is not the thermometer count");
endmodule : eqc_lane_status
`default_nettype wire

// *** test/eqc_lane_src.sv ***
// Partner model: lane transmitters driving thermometer levels and analysis flags
`timescale 1ns/100ps
`default_nettype none
module eqc_lane_src #(
  parameter int LANES = 16,
  parameter int THERM_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [LANES*5-1:0] level_cmd,
  input wire logic [LANES-1:0] above_cmd,
  input wire logic [LANES-1:0] below_cmd,
  output logic [LANES*THERM_W-1:0] lane_therm,
  output logic [LANES-1:0] above_flag,
  output logic [LANES-1:0] below_flag
);
  // Level k as k low bits set
  function automatic logic [THERM_W-1:0] therm(input logic [4:0] k);
    therm = '0;
    for (int i = 0; i < THERM_W; i++) therm[i] = (i < k);
  endfunction : therm

  // Lanes update just after each edge, like a real transmitter
  // thermometer and flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lane_therm <= '0;
      above_flag <= '0;
      below_flag <= '0;
    end else begin
      for (int n = 0; n < LANES; n++) lane_therm[n*THERM_W +: THERM_W] <= therm(level_cmd[n*5 +: 5]);
      above_flag <= above_cmd;
      below_flag <= below_cmd;
    end
  end
endmodule : eqc_lane_src
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the equalizer control bank
`timescale 1ns/100ps
`default_nettype none
`include "eqc_regs.svh"
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, flat_o, ovr_o, frz_o, irq;
  eqc_pkg::eqc_rate_t lane_rate = '0;
  eqc_pkg::eqc_mode_t mode_o;
  eqc_pkg::eqc_zero_t zc_o;
  logic [255:0] lane_therm;
  logic [15:0] ab_flag, bl_flag, ab_cmd = '0, bl_cmd = '0;
  logic [79:0] lvl_cmd = '0, str_o;
  logic [31:0] lift_o;
  int failures = 0, checked = 0, cycles = 0;

  eqc_bank DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_rate(lane_rate), .lane_therm(lane_therm), .analysis_above_flag(ab_flag),
    .analysis_below_flag(bl_flag), .eq_operating_mode(mode_o), .eq_flat_max_gain(flat_o),
    .level_override(ovr_o), .adapt_freeze(frz_o), .zero_code(zc_o), .lane_strength(str_o),
    .lane_gain_lift(lift_o), .irq(irq));
  eqc_lane_src src (.clk(clk), .rstn(rstn), .level_cmd(lvl_cmd), .above_cmd(ab_cmd),
    .below_cmd(bl_cmd), .lane_therm(lane_therm), .above_flag(ab_flag), .below_flag(bl_flag));

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [11:0] ra(input int idx);
    ra = {1'b0, idx[8:0], 2'b00};
  endfunction : ra

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, ra(idx), d, r, e);
  endtask : wr

  task automatic rd(input int idx, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, ra(idx), '0, r, e);
    check(nm, r, exp);
  endtask : rd

  // Let k edges pass, then look at settled outputs
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic drive(input logic [79:0] l, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    lvl_cmd <= l; ab_cmd <= a; bl_cmd <= b;
    settle(6);
  endtask : drive

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(`EQC_IDX_GLOBAL_CTRL, `EQC_RST_GLOBAL_CTRL, "ctrl");
    rd(`EQC_IDX_ZERO_SEL, `EQC_RST_ZERO_SEL, "zero_sel");
    for (int n = 0; n < 16; n++) rd(`EQC_IDX_LANE_SETUP + n, `EQC_RST_LANE_SETUP, "setup");
    check("flat", flat_o, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 2; o++) begin
        wr(`EQC_IDX_GLOBAL_CTRL, (o << 4) | 4 | m);
        settle(2);
        check("mode", mode_o, m);
        check("flat", flat_o, m == 0);
        check("override", ovr_o, m == 1 && o == 1);
        check("freeze", frz_o, m == 1 && o == 0);
      end
    end
    $display("test mode done");
  endtask : t_mode

  task automatic t_zero();
    logic [4:0] zt [8] = '{5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h19, 5'h10, 5'h08, 5'h00};
    logic [4:0] auto_z [4] = '{`EQC_ZERO_RATE01, `EQC_ZERO_RATE01, `EQC_ZERO_RATE2,
                               `EQC_ZERO_RATE3};
    wr(`EQC_IDX_GLOBAL_CTRL, 0);
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      lane_rate <= 2'(r);
      settle(5);
      check("auto_zero", zc_o, auto_z[r]);
    end
    wr(`EQC_IDX_GLOBAL_CTRL, 8);
    for (int i = 0; i < 8; i++) begin
      wr(`EQC_IDX_ZERO_SEL, zt[i]);
      settle(2);
      check("zero_code", zc_o, zt[i]);
    end
    wr(`EQC_IDX_GLOBAL_CTRL, 0);
    settle(2);
    check("zero_code", zc_o, auto_z[3]);
    $display("test zero done");
  endtask : t_zero

  task automatic t_lane();
    logic [7:0] v [16];
    wr(`EQC_IDX_GLOBAL_CTRL, 8'h11);
    // strength kept within 0 to 16
    for (int n = 0; n < 16; n++) v[n] = {1'b0, 2'(n % 4), 5'(n == 15 ? 16 : n)};
    for (int n = 0; n < 16; n++) wr(`EQC_IDX_LANE_SETUP + n, v[n]);
    settle(2);
    for (int n = 0; n < 16; n++) begin
      rd(`EQC_IDX_LANE_SETUP + n, v[n], "setup");
      check("strength", str_o[n*5 +: 5], v[n][4:0]);
      check("gain_lift", lift_o[n*2 +: 2], v[n][6:5]);
    end
    $display("test lane done");
  endtask : t_lane

  task automatic t_report();
    logic [79:0] l;
    logic [31:0] r;
    logic e;
    for (int n = 0; n < 16; n++) l[n*5 +: 5] = 5'((n + 1) % 17);
    drive(l, 16'h00f0, 16'h0f00);
    for (int n = 0; n < 16; n++) rd(`EQC_IDX_LANE_REPORT + n, {1'b0, ab_cmd[n], bl_cmd[n], l[n*5 +: 5]}, "report");
    wr(`EQC_IDX_LANE_REPORT, 8'hff);
    rd(`EQC_IDX_LANE_REPORT, {3'b000, l[4:0]}, "report_ro");
    apb(1'b0, ra(`EQC_IDX_ZERO_SEL + 1), '0, r, e);
    check("unmapped_err", e, 1'b1);
    check("unmapped_data", r, 0);
    $display("test report done");
  endtask : t_report

  task automatic t_freeze();
    wr(`EQC_IDX_GLOBAL_CTRL, 8'h01);
    drive({16{5'd5}}, '0, '0);
    wr(`EQC_IDX_GLOBAL_CTRL, 8'h0d);
    settle(2);
    check("freeze", frz_o, 1'b1);
    drive({16{5'd9}}, '0, '0);
    rd(`EQC_IDX_LANE_REPORT + 2, 5, "held_level");
    wr(`EQC_IDX_GLOBAL_CTRL, 8'h01);
    settle(6);
    rd(`EQC_IDX_LANE_REPORT + 2, 9, "new_level");
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_irq();
    wr(`EQC_IDX_INT_ENABLE, 0);
    wr(`EQC_IDX_INT_CLEAR, 7);
    rd(`EQC_IDX_INT_STATUS, 0, "status");
    rd(`EQC_IDX_INT_CLEAR, 0, "clear_reads");
    wr(`EQC_IDX_INT_ENABLE, 1);
    drive({16{5'd9}}, 16'h0008, '0);
    rd(`EQC_IDX_INT_STATUS, 1, "status");
    check("irq", irq, 1'b1);
    wr(`EQC_IDX_INT_ENABLE, 0);
    settle(1);
    check("irq_masked", irq, 1'b0);
    wr(`EQC_IDX_INT_ENABLE, 1);
    wr(`EQC_IDX_INT_CLEAR, 1);
    settle(1);
    check("irq_cleared", irq, 1'b0);
    rd(`EQC_IDX_INT_STATUS, 0, "status");
    $display("test irq done");
  endtask : t_irq

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_mode();
    t_zero();
    t_lane();
    t_report();
    t_freeze();
    t_irq();
    results();
  end
endmodule : testbench
`default_nettype wire
